// ---- src/dsadc_pkg.sv ----
// Package: register map, field positions, reset values and timing counts
package dsadc_pkg;
    // Register byte offsets; one aligned word each, so no two alias
    localparam logic [11:0] OFS_CONTROL = 12'h000;
    localparam logic [11:0] OFS_RESULT = 12'h018;
    localparam logic [11:0] OFS_START_STATUS = 12'h004;
    localparam logic [11:0] OFS_BANDGAP = 12'h008;
    localparam logic [11:0] OFS_IRQ_REQUEST = 12'h00C;
    localparam logic [11:0] OFS_IRQ_ENABLE = 12'h010;
    localparam logic [11:0] OFS_POWER = 12'h014;
    // Field positions
    localparam int CTL_REPEAT_BIT = 7;
    localparam int SS_START_BIT = 0;
    localparam int SS_ACTIVE_BIT = 1;
    localparam int SS_CHANNEL_BIT = 2;
    localparam int SS_BYPASS_BIT = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int RESULT_LSB = 2;
    localparam int RESULT_BITS = 14;
    // Reset values
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [7:0] BGT_RESET = 8'h00;
    // Timing: 32 us per conversion, 320 modulator samples each
    localparam int CONV_TIME_NS = 32000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int OVERSAMPLE = 320;
    localparam int CONV_CYCLES = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int SAMPLE_DIV = CONV_CYCLES / OVERSAMPLE;
    // Chip power states
    typedef enum logic [2:0]
    {
        PWR_ACTIVE, PWR_SLEEP, PWR_WATCH, PWR_SUBACTIVE,
        PWR_SUBSLEEP, PWR_STANDBY
    } power_state_t;
endpackage : dsadc_pkg

// ---- src/sample_divider.sv ----
// Sample-strobe divider for the modulator bit stream
`timescale 1ns/1ps
module sample_divider
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic run, // Count while high
    output logic tick // One-cycle sample strobe
);
    logic [3:0] cnt_ff;

    // Restart at each stop so a conversion begins on a clean phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_ff <= 4'h0;
        else if (!run || cnt_ff == 4'(dsadc_pkg::SAMPLE_DIV - 1))
            cnt_ff <= 4'h0;
        else
            cnt_ff <= cnt_ff + 4'h1;
    end

    assign tick = run && cnt_ff == 4'(dsadc_pkg::SAMPLE_DIV - 1);
endmodule : sample_divider

// ---- src/decimator.sv ----
// Decimation filter: second-order sinc reducing 320 bits to a 14-bit word
`timescale 1ns/1ps
module decimator
(
    input wire logic pclk, // System clock
    input wire logic presetn, // Async reset, active low
    input wire logic clear, // Start a fresh accumulation
    input wire logic sample, // Take one modulator bit
    input wire logic mod_bit, // Modulator output bit
    output logic [13:0] word // Scaled unsigned result
);
    logic [8:0] n_ff;
    logic [16:0] acc_ff;
    logic [16:0] scaled;

    // Triangle weights over the 320-bit frame, both ends tapered
    function automatic logic [7:0] weight(input logic [8:0] n);
        weight = (n < 9'd160) ? 8'(n >> 1) + 8'h01 : 8'(9'd319 - n) >> 1;
    endfunction : weight

    // Weighted sum of ones; a full-scale frame sums to 12800
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            n_ff <= 9'h000;
            acc_ff <= 17'h00000;
        end
        else if (clear)
        begin
            n_ff <= 9'h000;
            acc_ff <= 17'h00000;
        end
        else if (sample)
        begin
            n_ff <= n_ff + 9'h001;
            if (mod_bit)
                acc_ff <= acc_ff + 17'(weight(n_ff));
        end
    end

    // Scale 12800 by 1.28125 onto 14 bits; saturate the small overshoot
    assign scaled = acc_ff + (acc_ff >> 2) + (acc_ff >> 5);
    assign word = (scaled > 17'h03FFF) ? 14'h3FFF : scaled[13:0];
endmodule : decimator

// ---- src/dsadc_ctrl.sv ----
// Delta-sigma converter control: APB registers, sequencing, decimation
`timescale 1ns/1ps
// Behaviour
// [RULE_01] Result goes to upper 14 of 16 bits
// [RULE_02] Result read allowed anytime, undefined mid-conversion
// [RULE_03] Result held until next conversion begins
// [RULE_04] Result register untouched by reset
// [RULE_05] Result unsigned binary, bit 13 MSB
// [RULE_06] Sample at 320x rate, decimate to 14
// [RULE_07] One conversion takes 32 us
// [RULE_08] Two channels, one selected at once
// [RULE_09] Single-start write launches exactly one conversion
// [RULE_10] Active bit high during conversion, then idle
// [RULE_11] Done flag set; irq only when enabled
// [RULE_12] Single interrupt source: conversion end
// [RULE_13] Repeat bit starts back-to-back conversions
// [RULE_14] Repeat stops on clear, reset, low power
// [RULE_15] Start/status and result frozen below sleep
// [RULE_16] Control changeable only in active state
// [RULE_17] Start/status holds flag, channel, bypass bits
// [RULE_18] Bandgap trim drives reference adjust output
// [RULE_19] Module standby halts converter, keeps registers
// [RULE_20] Software waits 0.8 ms for reference
// [RULE_21] Software discards first result, shifts second
// [RULE_22] Repeat mode converts regardless of start bit
// [RULE_23] Start during conversion ignored
// [RULE_24] Done flag cleared only by software
module dsadc_ctrl
(
    input wire logic pclk, // System clock, 20 MHz
    input wire logic presetn, // Async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [2:0] power_state, // Chip power state
    input wire logic mod_bit, // Modulator one-bit stream
    output logic channel_sel, // 0: input one, 1: input two
    output logic amp_bypass, // Gain amplifier bypass
    output logic mod_enable, // Modulator running
    output logic [7:0] bandgap_trim, // Reference trim code
    output logic irq // Conversion-end interrupt request
);
    typedef enum logic [1:0] {S_IDLE, S_CONV, S_DONE} conv_state_t;

    conv_state_t state_ff;
    logic [7:0] control_ff;
    logic channel_ff;
    logic bypass_ff;
    logic [7:0] trim_ff;
    logic done_flag_ff;
    logic done_ie_ff;
    logic standby_ff;
    logic [15:0] result_ff;
    logic [15:0] cyc_ff;
    logic start_req_ff;
    logic sample;
    logic [13:0] word;
    logic wr_en;
    logic rd_en;
    logic runnable;
    logic frozen;
    logic ctl_ok;
    logic mapped;
    logic finish;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction : hit

    // Zero-wait APB; address decode for all registers
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && !penable && !pwrite;
    assign mapped = hit(paddr, dsadc_pkg::OFS_CONTROL)
        || hit(paddr, dsadc_pkg::OFS_RESULT)
        || hit(paddr, dsadc_pkg::OFS_START_STATUS)
        || hit(paddr, dsadc_pkg::OFS_BANDGAP)
        || hit(paddr, dsadc_pkg::OFS_IRQ_REQUEST)
        || hit(paddr, dsadc_pkg::OFS_IRQ_ENABLE)
        || hit(paddr, dsadc_pkg::OFS_POWER);

    // Freeze in watch and below; module standby freezes too
    assign frozen = (power_state != 3'(dsadc_pkg::PWR_ACTIVE)
        && power_state != 3'(dsadc_pkg::PWR_SLEEP)) || standby_ff; // see [RULE_15] see [RULE_19]
    assign ctl_ok = power_state == 3'(dsadc_pkg::PWR_ACTIVE)
        && !standby_ff; // see [RULE_16]
    assign runnable = !frozen;
    assign finish = state_ff == S_CONV
        && cyc_ff == 16'(dsadc_pkg::CONV_CYCLES - 1); // see [RULE_07]

    // APB ready rises in each access phase; unmapped addresses flag an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
        end
    end

    // Read data captured in setup, presented in access phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h00000000;
        else if (rd_en)
        begin
            prdata <= 32'h00000000;
            if (hit(paddr, dsadc_pkg::OFS_CONTROL))
                prdata[7:0] <= control_ff;
            if (hit(paddr, dsadc_pkg::OFS_RESULT))
                prdata[15:0] <= result_ff; // see [RULE_02]
            if (hit(paddr, dsadc_pkg::OFS_START_STATUS))
            begin
                prdata[dsadc_pkg::SS_ACTIVE_BIT] <= state_ff == S_CONV; // see [RULE_17]
                prdata[dsadc_pkg::SS_CHANNEL_BIT] <= channel_ff;
                prdata[dsadc_pkg::SS_BYPASS_BIT] <= bypass_ff;
            end
            if (hit(paddr, dsadc_pkg::OFS_BANDGAP))
                prdata[7:0] <= trim_ff;
            if (hit(paddr, dsadc_pkg::OFS_IRQ_REQUEST))
                prdata[dsadc_pkg::IRQ_DONE_BIT] <= done_flag_ff;
            if (hit(paddr, dsadc_pkg::OFS_IRQ_ENABLE))
                prdata[dsadc_pkg::IRQ_DONE_BIT] <= done_ie_ff;
            if (hit(paddr, dsadc_pkg::OFS_POWER))
                prdata[0] <= standby_ff;
        end
    end

    // Control register: writable only in active state
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            control_ff <= dsadc_pkg::CTL_RESET; // see [RULE_14]
        else if (wr_en && ctl_ok && hit(paddr, dsadc_pkg::OFS_CONTROL))
            control_ff <= pwdata[7:0]; // see [RULE_16]
    end

    // Start/status fields; channel and bypass steer the analog side
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_ff <= 1'b0;
            bypass_ff <= 1'b0;
            start_req_ff <= 1'b0;
        end
        else
        begin
            start_req_ff <= 1'b0;
            if (wr_en && !frozen
                && hit(paddr, dsadc_pkg::OFS_START_STATUS))
            begin
                channel_ff <= pwdata[dsadc_pkg::SS_CHANNEL_BIT]; // see [RULE_08]
                bypass_ff <= pwdata[dsadc_pkg::SS_BYPASS_BIT];
                start_req_ff <= pwdata[dsadc_pkg::SS_START_BIT]; // see [RULE_09]
            end
        end
    end

    // Bandgap trim keeps working in subactive, as the reference does
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            trim_ff <= dsadc_pkg::BGT_RESET;
        else if (wr_en && hit(paddr, dsadc_pkg::OFS_BANDGAP) && !standby_ff
            && (power_state == 3'(dsadc_pkg::PWR_ACTIVE)
            || power_state == 3'(dsadc_pkg::PWR_SUBACTIVE)))
            trim_ff <= pwdata[7:0]; // see [RULE_18]
    end

    // Interrupt enable and module standby control
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            done_ie_ff <= 1'b0;
            standby_ff <= 1'b0;
        end
        else if (wr_en)
        begin
            if (hit(paddr, dsadc_pkg::OFS_IRQ_ENABLE))
                done_ie_ff <= pwdata[dsadc_pkg::IRQ_DONE_BIT];
            if (hit(paddr, dsadc_pkg::OFS_POWER))
                standby_ff <= pwdata[0]; // see [RULE_19]
        end
    end

    // Done flag: write 0 clears; a completion in that cycle wins
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            done_flag_ff <= 1'b0;
        else if (finish)
            done_flag_ff <= 1'b1; // see [RULE_11] see [RULE_13]
        else if (wr_en && hit(paddr, dsadc_pkg::OFS_IRQ_REQUEST)
            && !pwdata[dsadc_pkg::IRQ_DONE_BIT])
            done_flag_ff <= 1'b0; // see [RULE_24]
    end

    // Sole interrupt source, gated by the enable
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= done_flag_ff && done_ie_ff; // see [RULE_11] see [RULE_12]
    end

    // Conversion sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_ff <= S_IDLE;
            cyc_ff <= 16'h0000;
        end
        else if (!runnable)
        begin
            // Watch and below, or module standby, aborts; repeat resumes only when the bit is set
            state_ff <= S_IDLE; // see [RULE_14]
            cyc_ff <= 16'h0000;
        end
        else
        begin
            case (state_ff)
                S_IDLE:
                begin
                    cyc_ff <= 16'h0000;
                    if (start_req_ff || control_ff[dsadc_pkg::CTL_REPEAT_BIT])
                        state_ff <= S_CONV; // see [RULE_09] see [RULE_22]
                end
                S_CONV:
                begin
                    // Start writes here are ignored: no restart path
                    if (finish)
                    begin
                        cyc_ff <= 16'h0000; // see [RULE_23]
                        state_ff <= S_DONE;
                    end
                    else
                        cyc_ff <= cyc_ff + 16'h0001;
                end
                S_DONE:
                begin
                    if (control_ff[dsadc_pkg::CTL_REPEAT_BIT])
                        state_ff <= S_CONV; // see [RULE_13]
                    else
                        state_ff <= S_IDLE; // see [RULE_10]
                end
                default: state_ff <= S_IDLE;
            endcase
        end
    end

    // Result keeps its value through reset; loaded only at completion
    always_ff @(posedge pclk)
    begin
        if (finish)
            result_ff <= {word, 2'b00}; // see [RULE_01] see [RULE_05] see [RULE_03] see [RULE_04]
    end

    // Modulator and pin-side outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mod_enable <= 1'b0;
            channel_sel <= 1'b0;
            amp_bypass <= 1'b0;
            bandgap_trim <= dsadc_pkg::BGT_RESET;
        end
        else
        begin
            mod_enable <= state_ff == S_CONV && runnable;
            channel_sel <= channel_ff;
            amp_bypass <= bypass_ff;
            bandgap_trim <= trim_ff;
        end
    end

    // Sample strobe at 320 per conversion
    sample_divider u_div
    (
        .pclk(pclk),
        .presetn(presetn),
        .run(state_ff == S_CONV),
        .tick(sample)
    ); // see [RULE_06]

    decimator u_dec
    (
        .pclk(pclk),
        .presetn(presetn),
        .clear(state_ff != S_CONV),
        .sample(sample),
        .mod_bit(mod_bit),
        .word(word)
    ); // see [RULE_06]

    chk_conv_length: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(state_ff == S_CONV) |-> (state_ff == S_CONV) [*8]) // see [RULE_07]
        else $error("conversion ended too early");
    chk_done_sets: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> done_flag_ff) // see [RULE_11]
        else $error("done flag not set at completion");
    chk_irq_gate: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(done_ie_ff)) // see [RULE_11]
        else $error("interrupt without enable");
    chk_result_hold: assert property (@(posedge pclk) disable iff (!presetn)
        !$past(finish) |-> $stable(result_ff)) // see [RULE_03]
        else $error("result changed without completion");
    chk_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == S_CONV && !finish && runnable)
        |=> state_ff == S_CONV && cyc_ff == $past(cyc_ff) + 16'h0001) // see [RULE_23]
        else $error("running conversion disturbed");
    chk_ctl_frozen: assert property (@(posedge pclk) disable iff (!presetn)
        !ctl_ok |=> $stable(control_ff)) // see [RULE_16]
        else $error("control changed outside active state");
    chk_freeze_stops: assert property (@(posedge pclk) disable iff (!presetn)
        frozen |=> state_ff == S_IDLE) // see [RULE_14]
        else $error("conversion continued in low power");
    chk_repeat_back: assert property (@(posedge pclk) disable iff (!presetn)
        (state_ff == S_DONE && runnable
        && control_ff[dsadc_pkg::CTL_REPEAT_BIT])
        |=> state_ff == S_CONV) // see [RULE_13]
        else $error("repeat mode did not continue");

    // Launch step: a start pulse seen in idle while running
    sequence launch_seq;
        state_ff == S_IDLE && start_req_ff && runnable;
    endsequence

    chk_single_launch: assert property (@(posedge pclk) disable iff (!presetn)
        launch_seq |=> state_ff == S_CONV) // see [RULE_09]
        else $error("single start did not launch");
    chk_result_load: assert property (@(posedge pclk) disable iff (!presetn)
        finish |=> result_ff == {$past(word), 2'b00}) // see [RULE_01]
        else $error("result not loaded at completion");
    chk_irq_source: assert property (@(posedge pclk) disable iff (!presetn)
        irq |-> $past(done_flag_ff)) // see [RULE_12]
        else $error("interrupt without done flag");
    chk_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        (done_flag_ff && !wr_en) |=> done_flag_ff) // see [RULE_24]
        else $error("done flag cleared by itself");
endmodule : dsadc_ctrl

// ---- tb/mod_model.sv ----
// Behavioural one-bit modulator facing the converter control block
`timescale 1ns/1ps
module mod_model
(
    input wire logic pclk, // System clock
    input wire logic enable, // Modulator running
    input wire logic level, // 1: full-scale input, 0: zero input
    output logic bit_out // One-bit stream
);
    logic idle_ff = 1'b0;

    // Stopped stream toggles, so a stale bit never passes for data
    always_ff @(posedge pclk)
        idle_ff <= ~idle_ff;

    // Constant input gives a constant density of ones
    assign bit_out = enable ? level : idle_ff;
endmodule : mod_model

// ---- tb/tb_top.sv ----
// Self-checking bench for the converter control block over APB
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_CTL = dsadc_pkg::OFS_CONTROL;
    localparam logic [11:0] A_RES = dsadc_pkg::OFS_RESULT;
    localparam logic [11:0] A_SS = dsadc_pkg::OFS_START_STATUS;
    localparam logic [11:0] A_BGT = dsadc_pkg::OFS_BANDGAP;
    localparam logic [11:0] A_IRQ = dsadc_pkg::OFS_IRQ_REQUEST;
    localparam logic [11:0] A_IEN = dsadc_pkg::OFS_IRQ_ENABLE;
    localparam logic [11:0] A_PWR = dsadc_pkg::OFS_POWER;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, mod_bit;
    logic channel_sel, amp_bypass, mod_enable, irq, level, slv;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, res_one, res_zero;
    logic [7:0] bandgap_trim;
    logic [2:0] power_state;
    int num_errors, n_tests, cyc, t0;

    dsadc_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_state(power_state), .mod_bit(mod_bit),
        .channel_sel(channel_sel), .amp_bypass(amp_bypass),
        .mod_enable(mod_enable), .bandgap_trim(bandgap_trim), .irq(irq));
    mod_model mod_u (.pclk(pclk), .enable(mod_enable), .level(level),
        .bit_out(mod_bit));

    // 50 ns period, cycle count for timing checks
    always #25 pclk = ~pclk;
    always @(posedge pclk)
        cyc <= cyc + 1;

    task automatic conclude();
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : conclude

    task automatic chk(input string nm, input logic [31:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask : chk

    // One APB transfer; request held until pready is sampled high
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        int n;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 16);
        rd = prdata;
        slv = pslverr;
        if (n >= 16)
        begin
            num_errors++;
            conclude();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : xfer

    // Poll the done flag; bounded well beyond one conversion
    task automatic wait_done();
        int n;
        n = 0;
        do
        begin
            xfer(1'b0, A_IRQ, 32'h0);
            n++;
        end
        while (rd[dsadc_pkg::IRQ_DONE_BIT] !== 1'b1 && n < 600);
        if (n >= 600)
        begin
            num_errors++;
            conclude();
        end
    endtask : wait_done

    task automatic wait_idle();
        int n;
        n = 0;
        while (mod_enable !== 1'b0 && n < 800)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 800)
        begin
            num_errors++;
            conclude();
        end
    endtask : wait_idle

    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        {psel, penable, pwrite, level} = 4'h0;
        paddr = 12'h000;
        pwdata = 32'h0;
        power_state = 3'h0;
        {num_errors, n_tests, cyc} = '0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("irq_rst", 32'h0, {31'h0, irq});
        // Unmapped address is refused with zero data
        xfer(1'b0, 12'h020, 32'h0);
        chk("slverr", 32'h1, {31'h0, slv});
        chk("unmap_rd", 32'h0, rd);
        xfer(1'b1, A_BGT, 32'h5A);
        @(posedge pclk);
        chk("trim_out", 32'h5A, {24'h0, bandgap_trim});
        // Reference settling time, 0.8 ms at 20 MHz
        repeat (16000) @(posedge pclk);
        xfer(1'b1, A_IEN, 32'h1);
        // Single shot on input two, bypass, full-scale stream
        level <= 1'b1;
        xfer(1'b1, A_SS, 32'hD);
        t0 = cyc;
        // Pin outputs follow the register one edge later
        @(posedge pclk);
        chk("chan", 32'h1, {31'h0, channel_sel});
        chk("bypass", 32'h1, {31'h0, amp_bypass});
        repeat (300) @(posedge pclk);
        xfer(1'b0, A_SS, 32'h0);
        chk("active", 32'h1, {31'h0, rd[1]});
        xfer(1'b1, A_SS, 32'hD);
        wait_idle();
        chk("conv_len", 32'h1, {31'h0, cyc - t0 inside {[636:648]}});
        repeat (2) @(posedge pclk);
        chk("irq_on", 32'h1, {31'h0, irq});
        xfer(1'b0, A_SS, 32'h0);
        chk("idle", 32'h0, {31'h0, rd[1]});
        xfer(1'b0, A_RES, 32'h0);
        res_one = rd;
        chk("res_pad", 32'h0, {res_one[31:16], 14'h0, res_one[1:0]});
        chk("res_nz", 32'h1, {31'h0, res_one[15:2] != 14'h0});
        repeat (100) @(posedge pclk);
        xfer(1'b0, A_RES, 32'h0);
        chk("res_hold", res_one, rd);
        chk("flag_hold", 32'h1, {31'h0, irq});
        // Clear flag, mask irq, zero input on channel one
        xfer(1'b1, A_IRQ, 32'h0);
        repeat (2) @(posedge pclk);
        chk("irq_clr", 32'h0, {31'h0, irq});
        xfer(1'b1, A_IEN, 32'h0);
        level <= 1'b0;
        xfer(1'b1, A_SS, 32'h1);
        wait_done();
        chk("irq_mask", 32'h0, {31'h0, irq});
        xfer(1'b0, A_RES, 32'h0);
        res_zero = rd;
        chk("res_ord", 32'h1, {31'h0, res_zero[15:2] < res_one[15:2]});
        // Reset once the conversion has ended keeps the result
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        xfer(1'b0, A_RES, 32'h0);
        chk("res_keep", res_zero, rd);
        // Repeat mode, no start bit; control frozen in sleep
        xfer(1'b1, A_CTL, 32'h80);
        wait_done();
        xfer(1'b1, A_IRQ, 32'h0);
        power_state <= 3'h1;
        xfer(1'b1, A_CTL, 32'h0);
        wait_done();
        // Second result kept, first discarded; shifted down to its 14-bit word
        xfer(1'b0, A_RES, 32'h0);
        chk("rep_word", 32'h0, rd >> 2);
        power_state <= 3'h0;
        xfer(1'b1, A_CTL, 32'h0);
        wait_idle();
        xfer(1'b1, A_IRQ, 32'h0);
        repeat (1500) @(posedge pclk);
        xfer(1'b0, A_IRQ, 32'h0);
        chk("rep_stop", 32'h0, {31'h0, rd[0]});
        // Watch state stops repeat and freezes start/status
        xfer(1'b1, A_CTL, 32'h80);
        repeat (100) @(posedge pclk);
        power_state <= 3'h2;
        repeat (4) @(posedge pclk);
        chk("watch_stop", 32'h0, {31'h0, mod_enable});
        xfer(1'b1, A_SS, 32'h4);
        @(posedge pclk);
        chk("ss_frozen", 32'h0, {31'h0, channel_sel});
        power_state <= 3'h0;
        xfer(1'b1, A_CTL, 32'h0);
        wait_idle();
        // Module standby halts conversion, keeps settings
        xfer(1'b1, A_BGT, 32'h5A);
        xfer(1'b1, A_PWR, 32'h1);
        xfer(1'b1, A_SS, 32'h5);
        xfer(1'b1, A_BGT, 32'hA5);
        repeat (20) @(posedge pclk);
        chk("mstby_run", 32'h0, {31'h0, mod_enable});
        chk("mstby_ch", 32'h0, {31'h0, channel_sel});
        chk("mstby_trim", 32'h5A, {24'h0, bandgap_trim});
        xfer(1'b1, A_PWR, 32'h0);
        conclude();
    end
endmodule : tb_top
